// ==== rpm_ctrl.sv ====
// Purpose: Reset sequencing and idle/power-down control with AHB registers.
// Assumes: Pins are asynchronous; bus signals come from hclk logic.
// Notes:   How it works
// How it works
// - Watchdog overflow starts internal reset.
// - Watchdog reset finishes bus cycle when appropriate.
// - Ready high after waits aborts cycle.
// - Watchdog end latches bits 12..8, clears 7..2.
// - Bidir enable drives reset pin low.
// - Reset output low until end of init.
// - Power-down config enables mode-pin pull-up.
// - Reset pin low enables mode-pin pull-down.
// - Short reset pulse with mode high: warm.
// - Long low reset, mode falls: cold reset.
// - Idle stops CPU, peripherals run.
// - Idle exits on reset or interrupt.
// - Power-down stops CPU and peripherals.
// - Protected power-down needs NMI low.
// - Interruptible power-down stops oscillator and PLL.
// - Wake pin restarts oscillator, pull-down on.
// - Enabled wake interrupt runs service routine.
// - Disabled wake leaves flag set.
// - Pending bus actions finish before sleeping.
// - No sleep when ready missed last access.
// - Bidir enable bit 5, cleared by reset.
// - Mode pin level picks warm or cold reset.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module rpm_ctrl
  import rpm_pkg::*;
#(
  parameter int P0_W = 13
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        reset_input_pin_n,
  input  wire logic        mode_pin,
  input  wire logic        nmi_pin_n,
  input  wire logic [7:0]  fast_ext_irq_pin,
  input  wire logic [7:0]  irq_enable,
  input  wire logic        any_irq,
  input  wire logic [P0_W-1:0] config_port_bits,
  input  wire logic        xbus_busy,
  input  wire logic        xbus_uses_ready,
  input  wire logic        xbus_after_waits,
  input  wire logic        xbus_ready_n,
  input  wire logic        last_ready_seen,
  output logic             xbus_abort,
  output logic             reset_output_pin_n,
  output logic             reset_pin_oe,
  output logic             reset_pin_out,
  output logic             mode_pullup_en,
  output logic             mode_pulldown_en,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             osc_pll_en,
  output logic             sys_reset,
  output logic             wake_to_isr
);

  initial begin
    if (P0_W != 13) $error("config port width must be 13");
  end

  rpm_state_s s_q;
  rpm_state_s s_d;

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  // All state lives in one struct so the reset image is a single constant.
  always_comb begin
    logic wr;
    logic rd;
    logic [7:0] wirq;
    logic short_ok;
    s_d = s_q;
    wr = s_q.ap && s_q.a.hwrite;
    rd = 1'b0;
    wirq = 8'h00;
    short_ok = 1'b0;
    s_d.wake = 1'b0;
    s_d.wake_isr = 1'b0;
    xbus_abort = 1'b0;
    // Three-stage sampling; a change counts when stages two and three agree.
    s_d.rin_s = {s_q.rin_s[1:0], reset_input_pin_n};
    s_d.mode_s = {s_q.mode_s[1:0], mode_pin};
    if (s_q.rin_s[1] == s_q.rin_s[2]) begin
      s_d.rin_f = s_q.rin_s[2];
    end
    if (s_q.mode_s[1] == s_q.mode_s[2]) begin
      s_d.mode_f = s_q.mode_s[2];
    end
    wirq = fast_ext_irq_pin & ~{8{s_q.osc_run}};
    // Pull-down on the mode pin follows a low reset pin or a wake.
    s_d.mode_pd = !s_q.rin_f || (s_q.st == RPM_PDOWN && |wirq);
    // Register writes.
    if (wr && s_q.a.haddr == RPM_SYSCFG_OFS) begin
      s_d.cfg = hwdata[7:0];
    end
    if (wr && s_q.a.haddr == RPM_WDOG_OFS) begin
      s_d.wdrel = hwdata[15:0];
    end
    // Hardware set wins over software clear.
    if (wr && s_q.a.haddr == RPM_WAKEFLG_OFS) begin
      s_d.wflag = s_q.wflag & ~hwdata[7:0];
    end
    // Watchdog runs from reset until disabled before end of init.
    if (!s_q.wd_off && s_q.st == RPM_RUN) begin
      s_d.wdog = s_q.wdog + 16'h0001;
    end
    if (wr && s_q.a.haddr == RPM_CMD_OFS) begin
      if (hwdata[RPM_CMD_WSERV]) begin
        s_d.wdog = s_q.wdrel;
      end
      if (hwdata[RPM_CMD_WDIS] && !s_q.inited) begin
        s_d.wd_off = 1'b1;
      end
      if (hwdata[RPM_CMD_END_OF_INIT_INSTRUCTION]) begin
        s_d.inited = 1'b1;
        s_d.reset_output_pin_n_n = 1'b1;
      end
    end
    unique case (s_q.st)
      RPM_RUN: begin
        if (wr && s_q.a.haddr == RPM_CMD_OFS) begin
          if (hwdata[RPM_CMD_SRST]) begin
            s_d.st = RPM_DRAIN;
            s_d.cnt = 13'(RPM_DRAIN_CYC);
            s_d.wd_rst = 1'b0;
          end else if ((hwdata[RPM_CMD_IDLE] || hwdata[RPM_CMD_POWERDOWN_INSTRUCTION])
                       && !(s_q.cfg[RPM_RDYEN_BIT] && !last_ready_seen)) begin
            // A missed ready drops the request; the core keeps running.
            s_d.slp = {hwdata[RPM_CMD_POWERDOWN_INSTRUCTION] && !hwdata[RPM_CMD_IDLE],
                       hwdata[RPM_CMD_IDLE]};
          end
        end
        // The request waits until the external bus has gone quiet.
        if (s_q.slp != 2'b00 && !xbus_busy) begin
          s_d.slp = 2'b00;
          if (s_q.slp[0]) begin
            s_d.st = RPM_IDLE;
            s_d.cpu_run = 1'b0;
          end else if (s_q.cfg[RPM_POWERDOWN_CONFIG_BIT_BIT] || !nmi_pin_n) begin
            s_d.st = RPM_PDOWN;
            s_d.cpu_run = 1'b0;
            s_d.per_run = 1'b0;
            s_d.osc_run = !s_q.cfg[RPM_POWERDOWN_CONFIG_BIT_BIT];
          end
        end
        if (&s_q.wdog && !s_q.wd_off) begin
          // Overflow: wait for the external cycle as needed.
          s_d.st = RPM_DRAIN;
          s_d.cnt = 13'(RPM_DRAIN_CYC);
          s_d.wd_rst = 1'b1;
          s_d.slp = 2'b00;
        end
      end
      RPM_IDLE: begin
        if (any_irq) begin
          s_d.st = RPM_RUN;
          s_d.cpu_run = 1'b1;
        end
      end
      RPM_PDOWN: begin
        if (|wirq || (!s_q.cfg[RPM_POWERDOWN_CONFIG_BIT_BIT] && any_irq)) begin
          s_d.osc_run = 1'b1;
          s_d.per_run = 1'b1;
          s_d.cpu_run = 1'b1;
          s_d.st = RPM_RUN;
          s_d.wflag = s_q.wflag | wirq;
          s_d.wake = |wirq;
          s_d.wake_isr = |(wirq & irq_enable);
        end
      end
      RPM_DRAIN: begin
        if (s_q.wd_rst) begin
          // Finish without ready or ready low; ready high aborts.
          if (!xbus_busy || (xbus_uses_ready && xbus_after_waits)) begin
            xbus_abort = xbus_busy && xbus_ready_n;
            s_d.st = RPM_SEQ;
            s_d.cnt = 13'(RPM_SEQ_CYC);
          end
        end else if (s_q.cnt == 13'h0000) begin
          s_d.st = RPM_SEQ;
          s_d.cnt = 13'(RPM_SEQ_CYC);
        end else begin
          s_d.cnt = s_q.cnt - 13'h0001;
        end
        s_d.sys_rst = 1'b1;
        s_d.reset_output_pin_n_n = 1'b0;
      end
      RPM_SEQ: begin
        s_d.sys_rst = 1'b1;
        s_d.cnt = s_q.cnt - 13'h0001;
        if (s_q.cnt == 13'h0001) begin
          s_d.st = RPM_HOLD;
        end
      end
      RPM_HOLD: begin
        // Sequence extends while the reset pin stays low.
        if (s_q.rin_f) begin
          s_d.st = RPM_RUN;
          s_d.sys_rst = 1'b0;
          s_d.slp = 2'b00;
          s_d.wdog = RPM_WDOG_RST;
          s_d.wd_off = 1'b0;
          s_d.inited = 1'b0;
          s_d.cpu_run = 1'b1;
          s_d.per_run = 1'b1;
          s_d.osc_run = 1'b1;
          s_d.mode_pu = s_q.cfg[RPM_POWERDOWN_CONFIG_BIT_BIT];
          s_d.cfg[RPM_BDRST_BIT] = 1'b0;
          if (s_q.wd_rst || s_q.cold == 1'b0) begin
            // Partial latch for watchdog and software reset.
            s_d.p0lat[12:8] = config_port_bits[12:8];
            s_d.p0lat[7:2] = 6'h00;
          end else begin
            s_d.p0lat = config_port_bits;
          end
          s_d.cold = 1'b0;
          s_d.wd_rst = 1'b0;
        end
      end
      default: s_d.st = RPM_RUN;
    endcase
    // A low reset pin with the mode pin high gives a warm reset.
    // Hold already waits for the pin, so our own drive cannot re-arm it.
    if (!s_q.rin_f && s_q.mode_f && s_q.st != RPM_DRAIN
        && s_q.st != RPM_SEQ && s_q.st != RPM_HOLD) begin
      short_ok = 1'b1;
      s_d.st = RPM_DRAIN;
      s_d.cnt = 13'(RPM_DRAIN_CYC);
      s_d.wd_rst = 1'b0;
      s_d.cold = 1'b1;
      s_d.cpu_run = 1'b1;
      s_d.per_run = 1'b1;
      s_d.osc_run = 1'b1;
    end
    // Bidirectional reset drive for internal resets.
    s_d.rin_oe = s_q.cfg[RPM_BDRST_BIT] && !s_q.cold
                 && (s_d.st == RPM_DRAIN || s_d.st == RPM_SEQ);
    // Bus slave: capture address phase, answer with zero wait states.
    s_d.ap = hsel && hready && htrans[1];
    s_d.a.htrans1 = htrans[1];
    s_d.a.hwrite = hwrite;
    s_d.a.haddr = haddr[7:0];
    rd = hsel && hready && htrans[1] && !hwrite;
    s_d.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (haddr[7:0])
        RPM_SYSCFG_OFS:  s_d.rdata = {24'h00_0000, s_q.cfg};
        RPM_STATUS_OFS:  s_d.rdata = {8'h00, 3'(s_q.st), s_q.p0lat,
                                      s_q.inited, s_q.wd_off, s_q.cpu_run,
                                      s_q.per_run, s_q.osc_run,
                                      s_q.reset_output_pin_n_n, s_q.mode_f, s_q.rin_f};
        RPM_WAKEFLG_OFS: s_d.rdata = {24'h00_0000, s_q.wflag};
        RPM_WDOG_OFS:    s_d.rdata = {s_q.wdrel, s_q.wdog};
        default:         s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (short_ok && s_q.st == RPM_RUN) begin
      s_d.sys_rst = 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Cold reset: the mode pin is low with the reset pin low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{st: RPM_SEQ, cnt: 13'(RPM_SEQ_CYC), wdog: RPM_WDOG_RST,
               wdrel: RPM_WDOG_RST, wd_off: 1'b0, wd_rst: 1'b0,
               inited: 1'b0, cfg: RPM_SYSCFG_RST, p0lat: 13'h0000,
               wflag: 8'h00, rin_s: 3'b111, mode_s: 3'b111,
               rin_f: 1'b1, mode_f: 1'b1, reset_output_pin_n_n: 1'b0,
               rin_oe: 1'b0, mode_pu: 1'b0, mode_pd: 1'b0,
               cpu_run: 1'b1, per_run: 1'b1, osc_run: 1'b1,
               wake: 1'b0, wake_isr: 1'b0, sys_rst: 1'b1, cold: 1'b1,
               ap: 1'b0, slp: 2'b00, a: '0, rdata: 32'h0000_0000};
    end else if (!s_q.rin_f && !s_q.mode_f) begin
      s_q <= '{st: RPM_HOLD, cnt: 13'h0000, wdog: RPM_WDOG_RST,
               wdrel: RPM_WDOG_RST, wd_off: 1'b0, wd_rst: 1'b0,
               inited: 1'b0, cfg: RPM_SYSCFG_RST, p0lat: s_q.p0lat,
               wflag: 8'h00, rin_s: s_d.rin_s, mode_s: s_d.mode_s,
               rin_f: s_d.rin_f, mode_f: s_d.mode_f, reset_output_pin_n_n: 1'b0,
               rin_oe: 1'b0, mode_pu: 1'b0, mode_pd: 1'b1,
               cpu_run: 1'b1, per_run: 1'b1, osc_run: 1'b1,
               wake: 1'b0, wake_isr: 1'b0, sys_rst: 1'b1, cold: 1'b1,
               ap: 1'b0, slp: 2'b00, a: '0,
               rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs other than xbus_abort straight from state flops; hreadyout, hresp and reset_pin_out are tied constants.
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign reset_output_pin_n = s_q.reset_output_pin_n_n;
  assign reset_pin_oe = s_q.rin_oe;
  assign reset_pin_out = 1'b0;
  assign mode_pullup_en = s_q.mode_pu;
  assign mode_pulldown_en = s_q.mode_pd;
  assign cpu_clk_en = s_q.cpu_run;
  assign periph_clk_en = s_q.per_run;
  assign osc_pll_en = s_q.osc_run;
  assign sys_reset = s_q.sys_rst;
  assign wake_to_isr = s_q.wake_isr;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  // Counts cycles spent in the reset sequence for the length check.
  logic [9:0] seq_len_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_len_q <= 10'h000;
    end else begin
      seq_len_q <= (s_q.st == RPM_SEQ) ? seq_len_q + 10'h001 : 10'h000;
    end
  end

  a_reset_output_pin_n_low: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.sys_rst |=> !reset_output_pin_n) else $error("reset out high");
  a_idle_cpu: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.st == RPM_IDLE |-> !cpu_clk_en && periph_clk_en)
    else $error("idle clocks wrong");
  a_idle_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.st == RPM_IDLE && any_irq && s_q.rin_f |=> s_q.st == RPM_RUN)
    else $error("idle not left");
  a_pdown_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.st == RPM_PDOWN |-> !cpu_clk_en && !periph_clk_en)
    else $error("powerdown clocks run");
  a_pdown_osc: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.st == RPM_PDOWN && s_q.cfg[RPM_POWERDOWN_CONFIG_BIT_BIT] |-> !osc_pll_en)
    else $error("oscillator running");
  a_bdrst_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.st == RPM_HOLD && s_q.rin_f |=> !s_q.cfg[RPM_BDRST_BIT])
    else $error("bidir bit kept");
  a_pd_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_q.rin_f |=> mode_pulldown_en) else $error("no pulldown");
  a_seq_len: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.st == RPM_SEQ && s_d.st != RPM_SEQ && s_q.mode_f
    |-> seq_len_q == 10'(RPM_SEQ_CYC - 1))
    else $error("sequence short");
  c_wd_reset: cover property (@(posedge hclk) disable iff (!hresetn)
    s_q.st == RPM_DRAIN && s_q.wd_rst);
  c_idle: cover property (@(posedge hclk) disable iff (!hresetn)
    s_q.st == RPM_IDLE ##1 s_q.st == RPM_RUN);
  c_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    s_q.wake);

endmodule // rpm_ctrl

// ==== rpm_pkg.sv ====
// Purpose: Shared constants and types for the reset and power-mode controller.
// Assumes: One 250 MHz clock, AHB-Lite register access.
// Notes:   Offsets are byte addresses of 32-bit words.
package rpm_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] RPM_SYSCFG_OFS  = 8'h00;  // Configuration.
  localparam logic [7:0] RPM_CMD_OFS     = 8'h04;  // Instruction strobes.
  localparam logic [7:0] RPM_STATUS_OFS  = 8'h08;  // State and latches.
  localparam logic [7:0] RPM_WAKEFLG_OFS = 8'h0C;  // Wake request flags.
  localparam logic [7:0] RPM_WDOG_OFS    = 8'h10;  // Watchdog reload.

  // Configuration fields.
  localparam int RPM_BDRST_BIT = 5;   // Bidirectional reset enable.
  localparam int RPM_POWERDOWN_CONFIG_BIT_BIT = 6;  // Interruptible power-down.
  localparam int RPM_RDYEN_BIT = 7;   // Ready handling enabled.

  // Command fields.
  localparam int RPM_CMD_END_OF_INIT_INSTRUCTION = 0;
  localparam int RPM_CMD_POWERDOWN_INSTRUCTION = 1;
  localparam int RPM_CMD_IDLE  = 2;
  localparam int RPM_CMD_SRST  = 3;
  localparam int RPM_CMD_WSERV = 4;
  localparam int RPM_CMD_WDIS  = 5;

  // Reset values and counts.
  localparam logic [7:0]  RPM_SYSCFG_RST = 8'h00;
  localparam logic [15:0] RPM_WDOG_RST   = 16'h0000;
  localparam int RPM_SEQ_NS  = 2048;  // Internal reset sequence, 1024 TCL.
  localparam int RPM_CLK_MHZ = 250;
  localparam int RPM_SEQ_CYC = (RPM_SEQ_NS * RPM_CLK_MHZ + 999) / 1000;
  localparam int RPM_DRAIN_CYC = 6;   // Access completion before reset.

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    RPM_RUN   = 3'b000,
    RPM_DRAIN = 3'b001,
    RPM_SEQ   = 3'b011,
    RPM_HOLD  = 3'b010,
    RPM_IDLE  = 3'b110,
    RPM_PDOWN = 3'b111
  } rpm_state_e;

  typedef struct packed {
    logic htrans1;
    logic hwrite;
    logic [7:0] haddr;
  } rpm_ahb_s;

  typedef struct packed {
    rpm_state_e  st;
    logic [12:0] cnt;
    logic [15:0] wdog;
    logic [15:0] wdrel;
    logic        wd_off;
    logic        wd_rst;
    logic        inited;
    logic [7:0]  cfg;
    logic [12:0] p0lat;
    logic [7:0]  wflag;
    logic [2:0]  rin_s;
    logic [2:0]  mode_s;
    logic        rin_f;
    logic        mode_f;
    logic        reset_output_pin_n_n;
    logic        rin_oe;
    logic        mode_pu;
    logic        mode_pd;
    logic        cpu_run;
    logic        per_run;
    logic        osc_run;
    logic        wake;
    logic        wake_isr;
    logic        sys_rst;
    logic        cold;
    logic        ap;
    logic [1:0]  slp;     // Pending sleep request: bit 0 idle, bit 1 power-down.
    rpm_ahb_s    a;
    logic [31:0] rdata;
  } rpm_state_s;

endpackage : rpm_pkg

// ==== rpm_far_end.sv ====
// Purpose: Far-side model of the reset pin wiring and reset-mode capacitor.
// Assumes: The reset pin has a pull-up; parties only ever pull it low.
// Notes:   Mode pin falls once the pull-down has run for CAP_CYC cycles.
`timescale 1ns/100ps
module rpm_far_end #(
  parameter int CAP_CYC = 1500
) (
  input  wire logic hclk,
  input  wire logic ext_rst_n,
  input  wire logic reset_pin_oe,
  input  wire logic reset_pin_out,
  input  wire logic mode_pullup_en,
  input  wire logic mode_pulldown_en,
  output logic      reset_input_pin_n,
  output logic      mode_pin
);
  int dis = 0;

  // ---------------------------------------------------------------------
  // Wired reset line
  // ---------------------------------------------------------------------
  // Either party may pull low; the pull-up wins only when both let go.
  assign reset_input_pin_n = ext_rst_n &
                             (reset_pin_oe ? reset_pin_out : 1'b1);

  // ---------------------------------------------------------------------
  // Mode capacitor
  // ---------------------------------------------------------------------
  // Recharge is faster than discharge, so short pulses never go cold.
  always @(posedge hclk) begin
    if (mode_pulldown_en === 1'b1)
      dis <= (dis < CAP_CYC) ? dis + 1 : dis;
    else
      dis <= (dis > 4) ? dis - ((mode_pullup_en === 1'b1) ? 4 : 2) : 0;
  end
  assign mode_pin = (dis < CAP_CYC);
endmodule // rpm_far_end

// ==== testbench.sv ====
// Purpose: Self-checking bench for the reset and power-mode controller.
// Assumes: Zero-wait AHB-Lite slave; bench is the only bus master.
// Notes:   Status bits are watched through one packed observation vector.
`timescale 1ns/100ps
module testbench import rpm_pkg::*;;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, rin_n, mode_pin, nmi_n = 1'b1;
  logic        ext_rst_n = 1'b1, any_irq = 1'b0, last_rdy = 1'b1;
  logic [7:0]  wake_pins = 8'h00, irq_en = 8'h00;
  logic [12:0] cfg_bits = 13'h0000;
  logic        busy = 1'b0, uses_rdy = 1'b0, after_w = 1'b0, rdy_n = 1'b0;
  logic        abort, rout_n, oe, pout, pu, pd, cpu, per, osc, srst, isr;
  logic        abort_seen = 1'b0, isr_seen = 1'b0;
  int          failures = 0, compares = 0, cycles = 0;
  // 0 cpu, 1 periph, 2 osc, 3 sys reset, 4 reset out, 5 abort,
  // 6 reset pin drive, 7 mode pull-down, 8 mode pin.
  wire [8:0] obs = {mode_pin, pd, oe, abort, rout_n, srst, osc, per, cpu};

  always #2 hclk = ~hclk;

  rpm_ctrl #(.P0_W(13)) i_rpm_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reset_input_pin_n(rin_n), .mode_pin(mode_pin),
    .nmi_pin_n(nmi_n), .fast_ext_irq_pin(wake_pins), .irq_enable(irq_en),
    .any_irq(any_irq), .config_port_bits(cfg_bits), .xbus_busy(busy),
    .xbus_uses_ready(uses_rdy), .xbus_after_waits(after_w),
    .xbus_ready_n(rdy_n), .last_ready_seen(last_rdy), .xbus_abort(abort),
    .reset_output_pin_n(rout_n), .reset_pin_oe(oe), .reset_pin_out(pout),
    .mode_pullup_en(pu), .mode_pulldown_en(pd), .cpu_clk_en(cpu),
    .periph_clk_en(per), .osc_pll_en(osc), .sys_reset(srst),
    .wake_to_isr(isr));

  rpm_far_end i_rpm_far_end (
    .hclk(hclk), .ext_rst_n(ext_rst_n), .reset_pin_oe(oe),
    .reset_pin_out(pout), .mode_pullup_en(pu), .mode_pulldown_en(pd),
    .reset_input_pin_n(rin_n), .mode_pin(mode_pin));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Sticky monitors catch one-cycle pulses between polls.
  always @(posedge hclk) begin
    cycles++;
    if (abort === 1'b1) abort_seen <= 1'b1;
    if (isr === 1'b1) isr_seen <= 1'b1;
    if (cycles == 20000) begin
      failures++;
      $display("BAD run timeout");
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Waits a bounded number of cycles for one watched bit to settle.
  task automatic wait_bit(input int i, input logic v, input int lim,
                          input string nm);
    int n;
    n = 0;
    while (obs[i] !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk(nm, {31'h0, obs[i]}, {31'h0, v});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // One single word transfer; read data is taken at the data-phase edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    chk("reset out", {31'h0, rout_n}, 32'h0);
    wait_bit(3, 1'b0, 2000, "first sequence");
    bus(0, RPM_SYSCFG_OFS, 32'h0);
    chk("config reset", rd, 32'h0);
    // Watchdog overflow with a slave that stalls, then one that finishes.
    for (int c = 0; c < 2; c++) begin
      cfg_bits <= c ? 13'h0AFF : 13'h15FF;
      busy <= 1'b1;
      uses_rdy <= 1'b1;
      after_w <= 1'b1;
      rdy_n <= (c == 0);
      abort_seen <= 1'b0;
      bus(1, RPM_SYSCFG_OFS, 32'h20);
      bus(1, RPM_WDOG_OFS, 32'hFFF0);
      bus(1, RPM_CMD_OFS, 32'h10);
      wait_bit(3, 1'b1, 100, "watchdog reset");
      cyc(8);
      busy <= 1'b0;
      wait_bit(6, 1'b1, 20, "reset pin driven");
      chk("abort", {31'h0, abort_seen}, {31'h0, c == 0});
      wait_bit(3, 1'b0, 2000, "sequence end");
      chk("reset out wdog", {31'h0, rout_n}, 32'h0);
      bus(0, RPM_STATUS_OFS, 32'h0);
      chk("latched", {21'h0, rd[20:10]},
          {21'h0, (c ? 5'h0A : 5'h15), 6'h00});
      bus(0, RPM_SYSCFG_OFS, 32'h0);
      chk("bidir cleared", {31'h0, rd[5]}, 32'h0);
      cyc(300);
    end
    bus(1, RPM_CMD_OFS, 32'h20);
    bus(1, RPM_CMD_OFS, 32'h01);
    wait_bit(4, 1'b1, 5, "reset out release");
    // Idle refused, delayed by a busy bus, then left by an interrupt.
    bus(1, RPM_SYSCFG_OFS, 32'h80);
    last_rdy <= 1'b0;
    bus(1, RPM_CMD_OFS, 32'h04);
    cyc(10);
    chk("idle refused", {31'h0, cpu}, 32'h1);
    busy <= 1'b1;
    last_rdy <= 1'b1;
    bus(1, RPM_CMD_OFS, 32'h04);
    cyc(10);
    chk("idle waits bus", {31'h0, cpu}, 32'h1);
    busy <= 1'b0;
    wait_bit(0, 1'b0, 20, "idle entered");
    chk("periph runs", {31'h0, per}, 32'h1);
    any_irq <= 1'b1;
    wait_bit(0, 1'b1, 20, "idle exit");
    any_irq <= 1'b0;
    // Protected power-down needs the NMI pin still low.
    bus(1, RPM_SYSCFG_OFS, 32'h00);
    bus(1, RPM_CMD_OFS, 32'h02);
    cyc(10);
    chk("pdown refused", {31'h0, cpu}, 32'h1);
    nmi_n <= 1'b0;
    bus(1, RPM_CMD_OFS, 32'h02);
    wait_bit(0, 1'b0, 20, "pdown cpu");
    chk("pdown periph", {31'h0, per}, 32'h0);
    any_irq <= 1'b1;
    wait_bit(0, 1'b1, 20, "pdown exit");
    any_irq <= 1'b0;
    nmi_n <= 1'b1;
    // Interruptible power-down, woken with the interrupt off, then on.
    for (int e = 0; e < 2; e++) begin
      irq_en <= e ? 8'h08 : 8'h00;
      isr_seen <= 1'b0;
      bus(1, RPM_SYSCFG_OFS, 32'h40);
      bus(1, RPM_CMD_OFS, 32'h02);
      wait_bit(2, 1'b0, 20, "osc stopped");
      chk("clocks frozen", {30'h0, cpu, per}, 32'h0);
      wake_pins <= 8'h08;
      cyc(12);
      wake_pins <= 8'h00;
      wait_bit(2, 1'b1, 20, "osc restart");
      wait_bit(0, 1'b1, 40, "cpu resumes");
      cyc(4);
      chk("service entry", {31'h0, isr_seen}, {31'h0, e[0]});
      bus(0, RPM_WAKEFLG_OFS, 32'h0);
      if (e == 0) begin
        chk("flag kept", {31'h0, rd[3]}, 32'h1);
        bus(1, RPM_WAKEFLG_OFS, 32'h08);
        bus(0, RPM_WAKEFLG_OFS, 32'h0);
        chk("flag cleared", {31'h0, rd[3]}, 32'h0);
      end
    end
    // Short pulse on the reset pin stays warm; a long one goes cold.
    bus(1, RPM_SYSCFG_OFS, 32'h00);
    ext_rst_n <= 1'b0;
    cyc(10);
    ext_rst_n <= 1'b1;
    wait_bit(3, 1'b1, 20, "warm reset");
    chk("mode high", {31'h0, mode_pin}, 32'h1);
    wait_bit(3, 1'b0, 2000, "warm done");
    cyc(600);
    ext_rst_n <= 1'b0;
    wait_bit(7, 1'b1, 10, "mode pull-down");
    wait_bit(8, 1'b0, 2000, "mode discharged");
    chk("cold reset", {30'h0, srst, rout_n}, 32'h2);
    ext_rst_n <= 1'b1;
    wait_bit(3, 1'b0, 3000, "cold done");
    print_verdict();
  end
endmodule // testbench
